// file: field_extract_funnel_unit.sv
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module field_extract_funnel_unit
	import field_extract_pkg::*;
#(
	parameter int REG_ADDR_W = 8
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [REG_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic op_valid,
	input wire logic [31:0] op_word,
	input wire logic [31:0] first_source_operand,
	input wire logic [31:0] second_reg_value,
	output logic wb_valid,
	output logic [7:0] wb_index,
	output logic [31:0] wb_data,
	output logic trap_req,
	output logic [7:0] trap_pointer_first,
	output logic [7:0] trap_pointer_second,
	output logic [7:0] trap_pointer_destination_register,
	output logic irq
);
	generate
		if (REG_ADDR_W < 5) begin : g_bad_addr
			$error("register address too narrow for the map");
		end
	endgenerate

	// Instruction field decode
	wire logic [7:0] opcode;
	wire logic [7:0] destination_register_index;
	wire logic [7:0] first_source_index;
	wire logic [7:0] second_source_index;
	wire logic immediate_select_bit;
	assign opcode = field_at(op_word, OPC_LO);
	assign destination_register_index = field_at(op_word, DESTINATION_REGISTER_LO);
	assign first_source_index = field_at(op_word, SRC1_LO);
	assign second_source_index = field_at(op_word, SRC2_LO);
	assign immediate_select_bit = op_word[IMM_SEL_BIT];

	wire logic is_merge;
	wire logic is_signed;
	wire logic is_funnel;
	wire logic is_float_add;
	wire logic is_extract;
	assign is_merge = (opcode == OPC_MERGE_REG) || (opcode == OPC_MERGE_IMM);
	assign is_signed = (opcode == OPC_SIGNED);
	assign is_funnel = (opcode == OPC_FUNNEL_REG) || (opcode == OPC_FUNNEL_IMM);
	assign is_float_add = (opcode == OPC_FLOAT_ADD);
	assign is_extract = is_merge || is_signed || is_funnel;

	// Software registers
	logic [FC_W-1:0] funnel_shift_count_ff;
	logic [BP_W-1:0] byte_pointer_ff;
	logic byte_order_bit_ff;
	logic [IRQ_W-1:0] irq_status_ff;
	logic [IRQ_W-1:0] irq_mask_ff;
	logic [FP_FLAG_W-1:0] fp_flags_ff;
	logic [31:0] reg_rdata_ff;

	// Second operand: register or zero-extended immediate
	wire logic [31:0] second_source_operand;
	assign second_source_operand = immediate_select_bit ?
		{24'h00_0000, second_source_index} : second_reg_value;

	wire logic [15:0] picked_half;
	halfword_pick #(
		.WORD_W(32)
	) u_pick (
		.word_in(first_source_operand),
		.byte_pointer(byte_pointer_ff),
		.byte_order_bit(byte_order_bit_ff),
		.half_out(picked_half)
	);

	wire logic [31:0] funnel_word;
	funnel_extract #(
		.WORD_W(32),
		.CNT_W(FC_W)
	) u_funnel (
		.upper_word(first_source_operand),
		.lower_word(second_source_operand),
		.shift_count(funnel_shift_count_ff),
		.result(funnel_word)
	);

	wire logic [31:0] merged_word;
	wire logic [31:0] signed_word;
	assign merged_word = {second_source_operand[31:16], picked_half};
	// Low field of 7E never reaches the result
	assign signed_word = {{16{picked_half[15]}}, picked_half};

	wire logic [31:0] nxt_wb_data;
	assign nxt_wb_data = is_funnel ? funnel_word : (is_signed ? signed_word : merged_word);

	wire logic nxt_wb_valid;
	wire logic nxt_trap;
	assign nxt_wb_valid = op_valid && is_extract;
	assign nxt_trap = op_valid && is_float_add;

	// Writeback
	logic wb_valid_ff;
	logic [7:0] wb_index_ff;
	logic [31:0] wb_data_ff;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_valid_ff <= 1'b0;
			wb_index_ff <= INDEX_RESET;
			wb_data_ff <= WORD_RESET;
		end else begin
			wb_valid_ff <= nxt_wb_valid;
			wb_index_ff <= nxt_wb_valid ? destination_register_index : wb_index_ff;
			wb_data_ff <= nxt_wb_valid ? nxt_wb_data : wb_data_ff;
		end
	end

	// Trap for software float emulation
	logic trap_ff;
	logic [7:0] trap_first_ff;
	logic [7:0] trap_second_ff;
	logic [7:0] trap_destination_register_ff;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			trap_ff <= 1'b0;
			trap_first_ff <= INDEX_RESET;
			trap_second_ff <= INDEX_RESET;
			trap_destination_register_ff <= INDEX_RESET;
		end else begin
			trap_ff <= nxt_trap;
			if (nxt_trap) begin
				trap_first_ff <= first_source_index;
				trap_second_ff <= second_source_index;
				trap_destination_register_ff <= destination_register_index;
			end
		end
	end

	// Register decode
	wire logic sel_status;
	wire logic sel_config;
	wire logic sel_irq_stat;
	wire logic sel_irq_mask;
	wire logic sel_trap_ptr;
	wire logic sel_fp_flags;
	assign sel_status = (reg_addr == REG_ADDR_W'(ALU_STATUS_ADDR));
	assign sel_config = (reg_addr == REG_ADDR_W'(CONFIG_ADDR));
	assign sel_irq_stat = (reg_addr == REG_ADDR_W'(IRQ_STATUS_ADDR));
	assign sel_irq_mask = (reg_addr == REG_ADDR_W'(IRQ_MASK_ADDR));
	assign sel_trap_ptr = (reg_addr == REG_ADDR_W'(TRAP_PTR_ADDR));
	assign sel_fp_flags = (reg_addr == REG_ADDR_W'(FP_FLAGS_ADDR));

	// ALU status only moves on a software write, never on an extract
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			funnel_shift_count_ff <= FC_RESET;
			byte_pointer_ff <= BP_RESET;
		end else if (reg_wr && sel_status) begin
			funnel_shift_count_ff <= reg_wdata[FC_LO +: FC_W];
			byte_pointer_ff <= reg_wdata[BP_LO +: BP_W];
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			byte_order_bit_ff <= BO_RESET;
			irq_mask_ff <= IRQ_RESET;
			fp_flags_ff <= FP_FLAGS_RESET;
		end else begin
			if (reg_wr && sel_config) begin
				byte_order_bit_ff <= reg_wdata[BO_BIT];
			end
			if (reg_wr && sel_irq_mask) begin
				irq_mask_ff <= reg_wdata[IRQ_W-1:0];
			end
			// Flags belong to the emulation handler; the trap leaves them alone
			if (reg_wr && sel_fp_flags) begin
				fp_flags_ff <= reg_wdata[FP_FLAG_W-1:0];
			end
		end
	end

	// Sticky events, write one to clear; a new event beats the clear
	wire logic [IRQ_W-1:0] irq_events;
	wire logic [IRQ_W-1:0] irq_clear;
	wire logic [IRQ_W-1:0] nxt_irq_status;
	assign irq_events = {nxt_wb_valid, nxt_trap};
	assign irq_clear = (reg_wr && sel_irq_stat) ? reg_wdata[IRQ_W-1:0] : IRQ_RESET;
	assign nxt_irq_status = (irq_status_ff & ~irq_clear) | irq_events;

	logic irq_ff;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_status_ff <= IRQ_RESET;
			irq_ff <= 1'b0;
		end else begin
			irq_status_ff <= nxt_irq_status;
			irq_ff <= |(nxt_irq_status & irq_mask_ff);
		end
	end

	// Read mux; unmapped reads return zero
	wire logic [31:0] read_word;
	assign read_word =
		sel_status ? {25'h000_0000, byte_pointer_ff, funnel_shift_count_ff} :
		sel_config ? {31'h0000_0000, byte_order_bit_ff} :
		sel_irq_stat ? {30'h0000_0000, irq_status_ff} :
		sel_irq_mask ? {30'h0000_0000, irq_mask_ff} :
		sel_trap_ptr ? {8'h00, trap_destination_register_ff, trap_second_ff, trap_first_ff} :
		sel_fp_flags ? {27'h000_0000, fp_flags_ff} : WORD_RESET;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_ff <= WORD_RESET;
		end else begin
			reg_rdata_ff <= reg_rd ? read_word : WORD_RESET;
		end
	end

	assign reg_rdata = reg_rdata_ff;
	assign wb_valid = wb_valid_ff;
	assign wb_index = wb_index_ff;
	assign wb_data = wb_data_ff;
	assign trap_req = trap_ff;
	assign trap_pointer_first = trap_first_ff;
	assign trap_pointer_second = trap_second_ff;
	assign trap_pointer_destination_register = trap_destination_register_ff;
	assign irq = irq_ff;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	wire logic [31:0] exp_rotate;
	assign exp_rotate = (first_source_operand << funnel_shift_count_ff) |
		(first_source_operand >> (6'h20 - {1'b0, funnel_shift_count_ff}));
	// Built from word shifts so it does not mirror the joined shifter
	wire logic [31:0] exp_funnel;
	assign exp_funnel = (first_source_operand << funnel_shift_count_ff) |
		(second_source_operand >> (6'h20 - {1'b0, funnel_shift_count_ff}));

	chk_half_select: assert property (
		op_valid && is_merge && !byte_order_bit_ff && byte_pointer_ff[1] == 1'b0
		|=> wb_data_ff[15:0] == $past(first_source_operand[31:16]))
		else $error("merge extract picked the wrong half");

	chk_merge_upper: assert property (
		op_valid && is_merge |=> wb_valid_ff && wb_data_ff[31:16] == $past(second_source_operand[31:16]))
		else $error("merge extract disturbed the upper half");

	chk_imm_zero_ext: assert property (
		op_valid && (is_funnel || is_merge) && immediate_select_bit
		|-> second_source_operand == {24'h00_0000, op_word[7:0]})
		else $error("immediate operand not zero-extended");

	chk_sign_fill: assert property (
		op_valid && is_signed |=> wb_data_ff[31:16] == {16{wb_data_ff[15]}}
		&& wb_index_ff == $past(destination_register_index))
		else $error("signed extract not sign-extended");

	chk_funnel_top: assert property (
		op_valid && is_funnel |=> wb_data_ff == $past(exp_funnel))
		else $error("funnel extract result wrong");

	chk_rotate_equal: assert property (
		op_valid && is_funnel && first_source_operand == second_source_operand
		|=> wb_data_ff == $past(exp_rotate))
		else $error("equal operands did not rotate");

	chk_count_source: assert property (
		op_valid && is_funnel && funnel_shift_count_ff == 5'h00
		|=> wb_data_ff == $past(first_source_operand))
		else $error("shift count taken from wrong place");

	chk_trap_load: assert property (
		op_valid && is_float_add |=> trap_ff && !wb_valid_ff
		&& trap_first_ff == $past(first_source_index)
		&& trap_second_ff == $past(second_source_index)
		&& trap_destination_register_ff == $past(destination_register_index))
		else $error("float add trap pointers wrong");

	chk_status_hold: assert property (
		!(reg_wr && sel_status) |=> $stable(funnel_shift_count_ff) && $stable(byte_pointer_ff))
		else $error("ALU status moved without a write");

	chk_irq_sticky: assert property (
		trap_ff |-> irq_status_ff[IRQ_TRAP_BIT])
		else $error("trap event lost from status");

	chk_lower_half: assert property (
		op_valid && (is_merge || is_signed) && byte_order_bit_ff && !byte_pointer_ff[1]
		|=> wb_data_ff[15:0] == $past(first_source_operand[15:0]))
		else $error("little-endian pick took the wrong half");

	chk_merge_imm: assert property (
		op_valid && is_merge && immediate_select_bit
		|=> wb_data_ff[31:16] == 16'h0000)
		else $error("merge with immediate kept upper bits");

	chk_wb_index: assert property (
		op_valid && is_extract
		|=> wb_valid_ff && wb_index_ff == $past(destination_register_index))
		else $error("extract wrote the wrong destination");

	chk_other_ignored: assert property (
		op_valid && !is_extract && !is_float_add
		|=> !wb_valid_ff && !trap_ff)
		else $error("foreign opcode produced an output");

	chk_wb_pulse: assert property (
		!(op_valid && is_extract)
		|=> !wb_valid_ff)
		else $error("writeback valid without an extract");

	chk_trap_hold: assert property (
		!nxt_trap
		|=> $stable(trap_first_ff) && $stable(trap_second_ff) && $stable(trap_destination_register_ff))
		else $error("trap pointers moved without a trap");

	chk_flags_hold: assert property (
		!(reg_wr && sel_fp_flags)
		|=> $stable(fp_flags_ff))
		else $error("float flags moved without a write");

	chk_set_wins: assert property (
		nxt_trap && reg_wr && sel_irq_stat && reg_wdata[IRQ_TRAP_BIT]
		|=> irq_status_ff[IRQ_TRAP_BIT])
		else $error("clear beat a new trap event");

	chk_irq_level: assert property (
		1'b1
		|=> irq_ff == |(irq_status_ff & $past(irq_mask_ff)))
		else $error("interrupt level disagrees with status");

	chk_read_data: assert property (
		reg_rd
		|=> reg_rdata_ff == $past(read_word))
		else $error("read data not presented");

	chk_read_idle: assert property (
		!reg_rd
		|=> reg_rdata_ff == WORD_RESET)
		else $error("read data left standing");
endmodule
`default_nettype wire

// file: field_extract_funnel_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
	samples_checked++; \
	if ((a) !== (b)) begin \
		n_errors++; \
		$display("[ERR] t=%0t got=%h exp=%h", $time, a, b); \
	end \
end
module field_extract_funnel_unit_bench;
	import field_extract_pkg::*;
	typedef struct packed {logic [31:0] op; logic [6:0] st; logic bo;} row_s;
	row_s rows[10] = '{'{32'h7c05_9011, 7'h00, 1'b0}, '{32'h7c06_9011, 7'h40, 1'b0},
		'{32'h7d07_90a5, 7'h00, 1'b1}, '{32'h7d08_90a5, 7'h60, 1'b1},
		'{32'h7e09_90ff, 7'h1f, 1'b0}, '{32'h7e0a_10ff, 7'h00, 1'b0},
		'{32'h7e0b_9000, 7'h00, 1'b1}, '{32'h7a0c_1090, 7'h00, 1'b0},
		'{32'h7a0d_1090, 7'h1f, 1'b0}, '{32'h7b0e_10a5, 7'h08, 1'b0}};
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, op_word = 32'h0, a_op, b_op, reg_rdata, wb_data;
	logic reg_wr = 1'b0, reg_rd = 1'b0, op_valid = 1'b0, wb_valid, trap_req, irq;
	logic [7:0] wb_index, tp_first, tp_second, tp_destination_register;
	int n_errors = 0, samples_checked = 0;

	always #25 ref_clk = ~ref_clk;

	regfile_model i_rf (.op_word(op_word), .first_source_operand(a_op), .second_reg_value(b_op));
	field_extract_funnel_unit i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.op_valid(op_valid), .op_word(op_word), .first_source_operand(a_op),
		.second_reg_value(b_op), .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data),
		.trap_req(trap_req), .trap_pointer_first(tp_first), .trap_pointer_second(tp_second),
		.trap_pointer_destination_register(tp_destination_register), .irq(irq));

	function automatic logic [31:0] regval(input logic [7:0] i);
		return {i, ~i, i ^ 8'h5a, i + 8'h33};
	endfunction

	function automatic logic [31:0] expect_of(input row_s r);
		logic [31:0] a, b;
		logic [15:0] h;
		logic [63:0] f;
		a = regval(r.op[15:8]);
		b = r.op[24] ? {24'h0, r.op[7:0]} : regval(r.op[7:0]);
		h = (r.st[6] ^ r.bo) ? a[15:0] : a[31:16];
		f = {a, b} << r.st[4:0];
		case (r.op[31:24])
			OPC_SIGNED: return {{16{h[15]}}, h};
			OPC_FUNNEL_REG, OPC_FUNNEL_IMM: return f[63:32];
			default: return {b[31:16], h};
		endcase
	endfunction

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask

	task automatic issue(input logic [31:0] w);
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_word <= w;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
	endtask

	task automatic complete_run();
		$display("checks=%0d errors=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		#1 `CHK({wb_valid, trap_req, irq, reg_rdata}, 35'h0)
		foreach (rows[i]) begin
			wr(ALU_STATUS_ADDR, {25'h0, rows[i].st});
			wr(CONFIG_ADDR, {31'h0, rows[i].bo});
			issue(rows[i].op);
			`CHK(wb_valid, 1'b1)
			`CHK(wb_index, rows[i].op[23:16])
			`CHK(wb_data, expect_of(rows[i]))
		end
		rd(ALU_STATUS_ADDR, 32'h0000_0008);
		wr(ALU_STATUS_ADDR, 32'h0000_0005);
		// Back-to-back issue, the second opcode is not one of ours
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_word <= 32'h7a03_4444;
		@(posedge ref_clk);
		op_word <= 32'h7f03_0000;
		#1 `CHK(wb_data, (regval(8'h44) << 5) | (regval(8'h44) >> 27))
		@(posedge ref_clk);
		op_valid <= 1'b0;
		#1 `CHK({wb_valid, trap_req, wb_index}, 10'h003)
		issue(32'hf011_2233);
		`CHK(trap_req, 1'b1)
		`CHK({tp_destination_register, tp_second, tp_first}, 24'h113322)
		`CHK(wb_valid, 1'b0)
		wr(TRAP_PTR_ADDR, 32'h0);
		rd(TRAP_PTR_ADDR, 32'h0011_3322);
		wr(FP_FLAGS_ADDR, 32'hffff_ffff);
		rd(FP_FLAGS_ADDR, 32'h0000_001f);
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20, 32'h0);
		rd(IRQ_STATUS_ADDR, 32'h3);
		`CHK(irq, 1'b0)
		wr(IRQ_MASK_ADDR, 32'h1);
		@(posedge ref_clk);
		#1 `CHK(irq, 1'b1)
		rd(IRQ_MASK_ADDR, 32'h1);
		wr(IRQ_STATUS_ADDR, 32'h1);
		rd(IRQ_STATUS_ADDR, 32'h2);
		`CHK(irq, 1'b0)
		// Trap and its clear on one edge: the event must win
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_word <= 32'hf021_3344;
		reg_wr <= 1'b1;
		reg_addr <= IRQ_STATUS_ADDR;
		reg_wdata <= 32'h1;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		reg_wr <= 1'b0;
		rd(IRQ_STATUS_ADDR, 32'h3);
		`CHK(irq, 1'b1)
		// Second reset in mid-run must clear state and outputs
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		#1 `CHK({wb_valid, trap_req, irq, wb_data, tp_first}, 43'h0)
		rd(ALU_STATUS_ADDR, 32'h0);
		rd(CONFIG_ADDR, 32'h0);
		rd(IRQ_MASK_ADDR, 32'h0);
		complete_run();
	end

	// Whole run needs under 120 cycles, so this only trips on a hang
	initial begin
		repeat (2000) @(posedge ref_clk);
		n_errors++;
		complete_run();
	end
endmodule
`default_nettype wire

// file: field_extract_pkg.sv
// Contract
// - The merging half-word extract picks one half of the first source operand by byte_pointer and byte_order_bit.
// - The merging extract replaces only the low half of the second source operand and writes the word back.
// - For opcodes 7C/7D and 7A/7B the immediate_select_bit picks the low-field register (0) or the zero-extended 8-bit immediate (1).
// - Opcode 7E picks a half-word the same way, sign-extends it to 32 bits and writes it back.
// - The bit-aligned extract joins the first source (upper) and second source (lower) into 64 bits and shifts left.
// - The shift distance comes from funnel_shift_count in the ALU status register, never from the instruction.
// - The top 32 bits of the shifted value are written back and the rest is dropped.
// - With equal source operands the bit-aligned extract is a left rotation by funnel_shift_count.
// - Opcode F0 decodes as the single-precision float add, which may touch the five float status flags.
// - The float add is not computed; it traps and loads the three trap pointers with first source, second source and destination.
package field_extract_pkg;
	localparam logic [7:0] OPC_MERGE_REG = 8'h7c;
	localparam logic [7:0] OPC_MERGE_IMM = 8'h7d;
	localparam logic [7:0] OPC_SIGNED = 8'h7e;
	localparam logic [7:0] OPC_FUNNEL_REG = 8'h7a;
	localparam logic [7:0] OPC_FUNNEL_IMM = 8'h7b;
	localparam logic [7:0] OPC_FLOAT_ADD = 8'hf0;

	localparam int OPC_LO = 24;
	localparam int DESTINATION_REGISTER_LO = 16;
	localparam int SRC1_LO = 8;
	localparam int SRC2_LO = 0;
	localparam int FIELD_W = 8;
	localparam int IMM_SEL_BIT = 24;

	localparam logic [7:0] ALU_STATUS_ADDR = 8'h00;
	localparam logic [7:0] CONFIG_ADDR = 8'h04;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h08;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h0c;
	localparam logic [7:0] TRAP_PTR_ADDR = 8'h10;
	localparam logic [7:0] FP_FLAGS_ADDR = 8'h14;

	localparam int FC_LO = 0;
	localparam int FC_W = 5;
	localparam int BP_LO = 5;
	localparam int BP_W = 2;
	localparam int BO_BIT = 0;
	localparam int IRQ_TRAP_BIT = 0;
	localparam int IRQ_DONE_BIT = 1;
	localparam int IRQ_W = 2;
	localparam int FP_FLAG_W = 5;

	localparam logic [FC_W-1:0] FC_RESET = 5'h00;
	localparam logic [BP_W-1:0] BP_RESET = 2'h0;
	localparam logic BO_RESET = 1'b0;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
	localparam logic [FP_FLAG_W-1:0] FP_FLAGS_RESET = 5'h00;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [7:0] INDEX_RESET = 8'h00;

	function automatic logic [7:0] field_at(input logic [31:0] word, input int lo);
		field_at = word[lo +: 8];
	endfunction
endpackage

// file: funnel_extract.sv
`timescale 1ns/1ps
`default_nettype none
module funnel_extract #(
	parameter int WORD_W = 32,
	parameter int CNT_W = 5
) (
	input wire logic [WORD_W-1:0] upper_word,
	input wire logic [WORD_W-1:0] lower_word,
	input wire logic [CNT_W-1:0] shift_count,
	output logic [WORD_W-1:0] result
);
	generate
		if ((1 << CNT_W) != WORD_W) begin : g_bad_count
			$error("funnel_extract count width must span the word");
		end
	endgenerate

	wire logic [2*WORD_W-1:0] joined;
	wire logic [2*WORD_W-1:0] shifted;
	assign joined = {upper_word, lower_word};
	assign shifted = joined << shift_count;
	// Low word falls away
	assign result = shifted[2*WORD_W-1:WORD_W];
endmodule
`default_nettype wire

// file: halfword_pick.sv
`timescale 1ns/1ps
`default_nettype none
module halfword_pick #(
	parameter int WORD_W = 32
) (
	input wire logic [WORD_W-1:0] word_in,
	input wire logic [1:0] byte_pointer,
	input wire logic byte_order_bit,
	output logic [WORD_W/2-1:0] half_out
);
	generate
		if (WORD_W % 2 != 0) begin : g_bad_width
			$error("halfword_pick needs an even word width");
		end
	endgenerate

	// Big-endian order puts pointer 0 on the upper half
	wire logic take_upper;
	assign take_upper = byte_order_bit ? byte_pointer[1] : ~byte_pointer[1];
	assign half_out = take_upper ? word_in[WORD_W-1:WORD_W/2] : word_in[WORD_W/2-1:0];
endmodule
`default_nettype wire

// file: regfile_model.sv
`timescale 1ns/1ps
`default_nettype none
module regfile_model (
	input wire logic [31:0] op_word,
	output logic [31:0] first_source_operand,
	output logic [31:0] second_reg_value
);
	// Contents are a fixed pattern of the index, so the bench can predict every operand
	function automatic logic [31:0] regval(input logic [7:0] i);
		return {i, ~i, i ^ 8'h5a, i + 8'h33};
	endfunction
	assign first_source_operand = regval(op_word[15:8]);
	assign second_reg_value = regval(op_word[7:0]);
endmodule
`default_nettype wire
